/* File: verilog/apq_pkg.sv */
// shared constants, tables and types for the angle output stage
package apq_pkg;
  // clock and update timing
  localparam int unsigned CLK_HZ         = 25_000_000;
  localparam int unsigned CLK_PERIOD_NS  = 40;
  localparam int unsigned T_ANG_NS       = 1000;
  localparam int unsigned T_ZCD_US       = 32;
  localparam int unsigned T_FIELD_US     = 128;
  localparam int unsigned ANG_CYC        = T_ANG_NS / CLK_PERIOD_NS;
  localparam int unsigned ZCD_CYC        = (T_ZCD_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned FIELD_CYC      = (T_FIELD_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned DIV_W          = 12;

  // serial register addresses
  localparam logic [5:0] ADR_ANGLE12     = 6'h20;
  localparam logic [5:0] ADR_FIELD       = 6'h2A;
  localparam logic [5:0] ADR_ANGLE15     = 6'h32;

  // resolution field in nonvolatile row 0x19
  localparam logic [7:0] ROW_RESOLUTION  = 8'h19;
  localparam int unsigned RES_LSB        = 0;
  localparam int unsigned RES_MSB        = 3;
  localparam logic [3:0] RES_CODE_MIN    = 4'h3;
  localparam logic [3:0] RES_CODE_MAX    = 4'hE;
  localparam logic [3:0] RES_SHIFT_OFS   = 4'h1;

  // pwm shape
  localparam int unsigned PWM_EDGE_DIV   = 20;
  localparam int unsigned PWM_ANG_BITS   = 12;
  localparam int unsigned PER_W          = 18;

  // carrier frequency in Hz, index = band * 16 + fine
  localparam int unsigned CARRIER_FINE_SELECT_HZ [0:127] = '{
    3125, 3101, 3077, 3053, 3030, 3008, 2985, 2963, 2941, 2920, 2899, 2878, 2857, 2837, 2817, 2797,
    2778, 2740, 2703, 2667, 2632, 2597, 2564, 2532, 2500, 2469, 2439, 2410, 2381, 2353, 2326, 2299,
    2273, 2222, 2174, 2128, 2083, 2041, 2000, 1961, 1923, 1887, 1852, 1818, 1786, 1754, 1724, 1695,
    1667, 1613, 1563, 1515, 1471, 1429, 1389, 1351, 1316, 1282, 1250, 1220, 1190, 1163, 1136, 1111,
    1087, 1042, 1000,  962,  926,  893,  862,  833,  806,  781,  758,  735,  714,  694,  676,  658,
     641,  610,  581,  556,  532,  510,  490,  472,  455,  439,  424,  410,  397,  385,  373,  362,
     352,  333,  316,  301,  287,  275,  263,  253,  243,  234,  225,  217,  210,  203,  197,  191,
     185,  175,  166,  157,  150,  143,  137,  131,  126,  121,  116,  112,  108,  105,  101,   98};

  // shadow copy of the nonvolatile configuration
  typedef struct packed {
    logic [14:0] zero_offset;
    logic [3:0]  res_code;
    logic        abi_invert;
    logic [3:0]  carrier_fine_select;
    logic [2:0]  carrier_band_select;
  } apq_cfg_t;

  // quadrature outputs
  typedef struct packed {
    logic a;
    logic b;
    logic idx;
  } apq_abi_t;

  typedef enum logic [1:0] {
    ST_LOAD = 2'b01,
    ST_RUN  = 2'b10
  } apq_state_t;
endpackage : apq_pkg

/* File: verilog/apq_core.sv */
// angle output stage: serial snapshot, pwm and quadrature encoder outputs
`timescale 1ns/10ps

module apq_core
  import apq_pkg::*;
#(
  parameter int unsigned WADR_W = 8
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              resetn,
  // processed samples from the signal paths
  input  wire logic [14:0]       main_angle,
  input  wire logic [14:0]       zcd_angle_in,
  input  wire logic [15:0]       field_in,
  input  wire logic              err_flag,
  input  wire logic              uv_flag,
  // nonvolatile contents read at power-up
  input  wire logic [14:0]       nv_zero_offset,
  input  wire logic [15:0]       nv_resolution_row,
  input  wire logic              nv_abi_invert,
  input  wire logic [15:0]       pwm_settings_row,
  // serial read port, frame start is the first serial clock edge
  input  wire logic              rd_frame_start,
  input  wire logic [5:0]        rd_addr,
  output logic [15:0]            rd_data,
  output logic                   rd_valid,
  // extended write pointer
  input  wire logic              wadr_load,
  input  wire logic [WADR_W-1:0] wadr_value,
  output logic [WADR_W-1:0]      write_adr,
  // secondary path angle and run status
  output logic [14:0]            zcd_angle,
  output logic                   ready,
  // open-drain pwm pin, pulls low while enabled
  output logic                   pwm_o,
  output logic                   pwm_oe,
  // encoder pins
  output apq_abi_t               abi
);

  apq_state_t             state, next_state;
  apq_cfg_t               cfg, next_cfg;
  logic [WADR_W-1:0]      next_write_adr;
  logic [DIV_W-1:0]       ang_div, next_ang_div, zcd_div, next_zcd_div, fld_div, next_fld_div;
  logic                   ang_tick, zcd_tick, fld_tick;
  logic [14:0]            ang15, next_ang15, next_zcd_angle;
  logic [15:0]            field, next_field, next_rd_data;
  logic                   next_rd_valid;
  logic [11:0]            ang12;
  logic                   run;

  assign run      = (state == ST_RUN);
  assign ready    = run;
  assign ang12    = ang15[14:3];
  assign pwm_o    = 1'b0;
  assign ang_tick = run && (ang_div == DIV_W'(ANG_CYC - 1));
  assign zcd_tick = run && (zcd_div == DIV_W'(ZCD_CYC - 1));
  assign fld_tick = run && (fld_div == DIV_W'(FIELD_CYC - 1));

  // power-up load sequence and shadow configuration
  always_comb begin
    next_state     = state;
    next_cfg       = cfg;
    next_write_adr = write_adr;
    case (state)
      ST_LOAD: begin
        next_cfg.zero_offset         = nv_zero_offset;
        next_cfg.res_code            = nv_resolution_row[RES_MSB:RES_LSB];
        next_cfg.abi_invert          = nv_abi_invert;
        next_cfg.carrier_fine_select = pwm_settings_row[3:0];
        next_cfg.carrier_band_select = pwm_settings_row[6:4];
        next_state                   = ST_RUN;
      end
      ST_RUN: begin
        if (wadr_load) begin
          next_write_adr = wadr_value;
        end
      end
      default: next_state = ST_LOAD;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state     <= ST_LOAD;
      cfg       <= '0;
      write_adr <= '0;
    end else begin
      state     <= next_state;
      cfg       <= next_cfg;
      write_adr <= next_write_adr;
    end
  end

  // update dividers and angle registers; values only move on their tick
  always_comb begin
    next_ang_div   = ang_tick ? '0 : (run ? DIV_W'(ang_div + 1'b1) : '0);
    next_zcd_div   = zcd_tick ? '0 : (run ? DIV_W'(zcd_div + 1'b1) : '0);
    next_fld_div   = fld_tick ? '0 : (run ? DIV_W'(fld_div + 1'b1) : '0);
    next_ang15     = ang_tick ? 15'(main_angle - cfg.zero_offset) : ang15;
    next_zcd_angle = zcd_tick ? zcd_angle_in : zcd_angle;
    next_field     = fld_tick ? field_in : field;
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ang_div   <= '0;
      zcd_div   <= '0;
      fld_div   <= '0;
      ang15     <= '0;
      zcd_angle <= '0;
      field     <= '0;
    end else begin
      ang_div   <= next_ang_div;
      zcd_div   <= next_zcd_div;
      fld_div   <= next_fld_div;
      ang15     <= next_ang15;
      zcd_angle <= next_zcd_angle;
      field     <= next_field;
    end
  end

  // serial snapshot: whole word taken at frame start, later updates cannot tear it
  always_comb begin
    next_rd_data  = rd_data;
    next_rd_valid = 1'b0;
    if (rd_frame_start && run) begin
      next_rd_valid = 1'b1;
      case (rd_addr)
        ADR_ANGLE12: next_rd_data = {1'b0, err_flag, uv_flag,
                                     ~(^{err_flag, uv_flag, ang12}), ang12};
        ADR_ANGLE15: next_rd_data = {1'b0, ang15};
        ADR_FIELD:   next_rd_data = field;
        default:     next_rd_data = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rd_data  <= 16'h0000;
      rd_valid <= 1'b0;
    end else begin
      rd_data  <= next_rd_data;
      rd_valid <= next_rd_valid;
    end
  end

  // carrier tables; each entry is an elaboration constant so no divider is built
  logic [PER_W-1:0] per_tab  [128];
  logic [PER_W-1:0] lead_tab [128];
  for (genvar i = 0; i < 128; i++) begin : g_carrier
    assign per_tab[i]  = PER_W'(CLK_HZ / CARRIER_FINE_SELECT_HZ[i]);
    assign lead_tab[i] = PER_W'((CLK_HZ / CARRIER_FINE_SELECT_HZ[i]) / PWM_EDGE_DIV);
  end

  logic [6:0]       sel;
  logic [PER_W-1:0] pcnt, next_pcnt, per_l, next_per_l, lead_l, next_lead_l;
  logic [PER_W-1:0] high_l, next_high_l, span;
  logic [PER_W+PWM_ANG_BITS-1:0] prod;
  logic             pwrap, next_pwm_oe;

  assign sel   = {cfg.carrier_band_select, cfg.carrier_fine_select};
  assign span  = PER_W'(per_tab[sel] - {lead_tab[sel][PER_W-2:0], 1'b0});
  assign prod  = span * ang12;
  assign pwrap = (pcnt >= PER_W'(per_l - 1'b1));

  // compare values reload only at wrap, so a period never mixes two angles
  always_comb begin
    next_pcnt   = pwrap ? '0 : PER_W'(pcnt + 1'b1);
    next_per_l  = per_l;
    next_lead_l = lead_l;
    next_high_l = high_l;
    if (pwrap) begin
      next_per_l  = per_tab[sel];
      next_lead_l = lead_tab[sel];
      next_high_l = PER_W'(lead_tab[sel] + prod[PER_W+PWM_ANG_BITS-1:PWM_ANG_BITS]);
    end
    next_pwm_oe = !(run && (next_pcnt < next_high_l));
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pcnt   <= '0;
      per_l  <= PER_W'(1);
      lead_l <= '0;
      high_l <= '0;
      pwm_oe <= 1'b1;
    end else begin
      pcnt   <= next_pcnt;
      per_l  <= next_per_l;
      lead_l <= next_lead_l;
      high_l <= next_high_l;
      pwm_oe <= next_pwm_oe;
    end
  end

  // quadrature: state index is the angle shifted down to the selected step
  logic       res_ok;
  logic [3:0] shamt;
  logic [14:0] qidx;
  apq_abi_t   raw, next_abi;

  assign res_ok = (cfg.res_code >= RES_CODE_MIN) && (cfg.res_code <= RES_CODE_MAX);
  assign shamt  = 4'(cfg.res_code - RES_SHIFT_OFS);
  assign qidx   = ang15 >> shamt;
  assign raw.a   = qidx[1];
  assign raw.b   = qidx[1] ^ qidx[0];
  assign raw.idx = (qidx == 15'h0000);

  // invalid or factory codes freeze the pins rather than guess a resolution
  always_comb begin
    next_abi = abi;
    if (run && res_ok) begin
      next_abi = raw ^ {3{cfg.abi_invert}};
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      abi <= '0;
    end else begin
      abi <= next_abi;
    end
  end

  a_ang_hold: assert property (@(posedge mclk) disable iff (!resetn)
    $changed(ang15) |-> $past(ang_tick)) else $error("angle changed off tick");
  a_ang_rate: assert property (@(posedge mclk) disable iff (!resetn)
    ang_tick |=> !ang_tick [*8]) else $error("angle tick too close");
  a_zcd_rate: assert property (@(posedge mclk) disable iff (!resetn)
    $changed(zcd_angle) |-> $past(zcd_div) == DIV_W'(ZCD_CYC - 1)) else $error("zcd bad rate");
  a_fld_rate: assert property (@(posedge mclk) disable iff (!resetn)
    $changed(field) |-> $past(fld_div) == DIV_W'(FIELD_CYC - 1)) else $error("field bad rate");
  a_rd_snap: assert property (@(posedge mclk) disable iff (!resetn)
    (rd_frame_start && run && rd_addr == ADR_ANGLE15) |=> rd_data == {1'b0, $past(ang15)})
    else $error("snapshot mismatch");
  a_rd_stable: assert property (@(posedge mclk) disable iff (!resetn)
    !rd_frame_start |=> $stable(rd_data)) else $error("snapshot moved");
  a_pwm_lead: assert property (@(posedge mclk) disable iff (!resetn)
    (run && $past(run) && pcnt < lead_l) |-> !pwm_oe) else $error("pwm lead not high");
  a_pwm_tail: assert property (@(posedge mclk) disable iff (!resetn)
    (lead_l != 0 && pcnt >= PER_W'(per_l - lead_l)) |-> pwm_oe) else $error("pwm tail not low");
  a_pwm_load: assert property (@(posedge mclk) disable iff (!resetn)
    !$past(pwrap) |-> $stable(high_l)) else $error("compare moved mid period");
  a_quad_gray: assert property (@(posedge mclk) disable iff (!resetn)
    ($past(ang15) + 15'h0001 == ang15 || ang15 + 15'h0001 == $past(ang15))
      |=> !($changed(abi.a) && $changed(abi.b))) else $error("two pins switched");
  a_load_once: assert property (@(posedge mclk) disable iff (!resetn)
    state == ST_LOAD |=> state == ST_RUN && cfg.zero_offset == $past(nv_zero_offset))
    else $error("shadow load failed");
  a_wadr_zero: assert property (@(posedge mclk)
    !resetn |=> write_adr == '0) else $error("write pointer not cleared");

endmodule : apq_core

/* File: test/apq_rx_model.sv */
// quadrature receiver model that tracks encoder position
`timescale 1ns/10ps
module apq_rx_model
  import apq_pkg::*;
#(
  parameter int unsigned STEPS = 4
) (
  // clock and reset
  input  wire logic     mclk,
  input  wire logic     resetn,
  // encoder pins
  input  wire apq_abi_t abi,
  // accumulated position in quadrature steps
  output logic [15:0]   pos
);
  logic [1:0] prev;
  logic [1:0] cur;

  // gray to binary so one step forward is always +1
  assign cur = {abi.a, abi.a ^ abi.b};

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      prev <= 2'h0;
      pos  <= 16'h0;
    end else begin
      prev <= cur;
      if (cur - prev == 2'h1) begin
        pos <= (pos == 16'(STEPS - 1)) ? 16'h0 : pos + 16'h1;
      end else if (cur - prev == 2'h3) begin
        pos <= (pos == 16'h0) ? 16'(STEPS - 1) : pos - 16'h1;
      end
    end
  end
endmodule : apq_rx_model

/* File: test/testbench.sv */
// self-checking bench for the angle output stage
`timescale 1ns/10ps
module testbench
  import apq_pkg::*;
;
  localparam logic [14:0] ZOFS = 15'h0100;
  logic mclk, resetn, err_flag, uv_flag, nv_abi_invert, rd_frame_start, rd_valid;
  logic wadr_load, ready, pwm_o, pwm_oe;
  logic [14:0] main_angle, zcd_angle_in, nv_zero_offset, zcd_angle;
  logic [15:0] field_in, nv_resolution_row, pwm_settings_row, rd_data, pos, word;
  logic [5:0]  rd_addr;
  logic [7:0]  wadr_value, write_adr;
  apq_abi_t    abi;
  int          num_errors = 0;
  int          n_compared = 0;

  apq_core dut (.mclk(mclk), .resetn(resetn), .main_angle(main_angle),
    .zcd_angle_in(zcd_angle_in), .field_in(field_in), .err_flag(err_flag),
    .uv_flag(uv_flag), .nv_zero_offset(nv_zero_offset), .nv_resolution_row(nv_resolution_row),
    .nv_abi_invert(nv_abi_invert), .pwm_settings_row(pwm_settings_row),
    .rd_frame_start(rd_frame_start), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_valid(rd_valid), .wadr_load(wadr_load), .wadr_value(wadr_value),
    .write_adr(write_adr), .zcd_angle(zcd_angle), .ready(ready), .pwm_o(pwm_o),
    .pwm_oe(pwm_oe), .abi(abi));

  apq_rx_model #(.STEPS(4)) rx (.mclk(mclk), .resetn(resetn), .abi(abi), .pos(pos));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic do_reset();
    int n;
    n = 0;
    resetn = 1'b0;
    repeat (2) @(posedge mclk);
    #1 resetn = 1'b1;
    while (ready !== 1'b1 && n < 10) begin
      @(posedge mclk);
      #1 n++;
    end
  endtask : do_reset

  // angle lands within one 25 cycle tick, pins one cycle later
  task automatic set_ang(input logic [14:0] a);
    main_angle = a + ZOFS;
    repeat (30) @(posedge mclk);
    #1;
  endtask : set_ang

  task automatic rd(input logic [5:0] adr, input logic [15:0] exp);
    rd_addr = adr;
    rd_frame_start = 1'b1;
    @(posedge mclk);
    #1 rd_frame_start = 1'b0;
    check(32'(rd_valid), 32'h1, "read valid");
    check(32'(rd_data), 32'(exp), "read data");
  endtask : rd

  // band 0 fine 0: period 8000 cycles, lead 400, span 7200
  task automatic pwm_meas(input int exp_hi);
    int hi;
    int lo;
    hi = 0;
    lo = 0;
    // skip a high phase already under way, it may carry the old angle
    while (pwm_oe === 1'b0 && lo < 9000) begin
      @(posedge mclk);
      #1 lo++;
    end
    while (pwm_oe !== 1'b0 && lo < 18000) begin
      @(posedge mclk);
      #1 lo++;
    end
    lo = 0;
    while (pwm_oe === 1'b0 && hi < 9000) begin
      @(posedge mclk);
      #1 hi++;
    end
    while (pwm_oe !== 1'b0 && lo < 9000) begin
      @(posedge mclk);
      #1 lo++;
    end
    check(32'(hi), 32'(exp_hi), "pwm high time");
    check(32'(hi + lo), 32'd8000, "pwm period");
  endtask : pwm_meas

  initial begin
    #(80000 * 40);
    num_errors++;
    $display("ERROR %0t: watchdog expired", $time);
    give_verdict();
  end

  initial begin
    logic [1:0] q;
    logic [15:0] pos0;
    resetn = 1'b0;
    main_angle = ZOFS;
    zcd_angle_in = 15'h2345;
    field_in = 16'hBEEF;
    err_flag = 1'b1;
    uv_flag = 1'b0;
    nv_zero_offset = ZOFS;
    nv_resolution_row = 16'h000E;
    nv_abi_invert = 1'b0;
    pwm_settings_row = 16'h0000;
    rd_frame_start = 1'b0;
    rd_addr = 6'h00;
    wadr_load = 1'b0;
    wadr_value = 8'h00;
    do_reset();
    check(32'(write_adr), 32'h0, "write pointer after power-up");
    set_ang(15'h1234);
    rd(ADR_ANGLE15, 16'h1234);
    word = {1'b0, 1'b1, 1'b0, ~^{1'b1, 1'b0, 12'h246}, 12'h246};
    rd(ADR_ANGLE12, word);
    set_ang(15'h5678);
    check(32'(rd_data), 32'(word), "frame held after update");
    rd(6'h3F, 16'h0000);
    set_ang(15'h7FF8);
    pwm_meas(7598);
    set_ang(15'h0000);
    pwm_meas(400);
    // earlier angle jumps already moved the receiver, so count from here
    pos0 = pos;
    for (int k = 1; k <= 4; k++) begin
      set_ang(15'(k * 32'h2000));
      q = 2'(k);
      check(32'(abi), 32'({q[1], q[1] ^ q[0], q == 2'h0}), "encoder pins");
      check(32'(pos), 32'((pos0 + k) % 4), "receiver count up");
    end
    set_ang(15'h6000);
    check(32'(abi), 32'h4, "encoder pins going down");
    check(32'(pos), 32'((pos0 + 3) % 4), "receiver count down");
    wadr_value = 8'h5A;
    wadr_load = 1'b1;
    @(posedge mclk);
    #1 wadr_load = 1'b0;
    @(posedge mclk);
    #1 check(32'(write_adr), 32'h5A, "write pointer load");
    check(32'(zcd_angle), 32'h2345, "secondary angle");
    rd(ADR_FIELD, 16'hBEEF);
    do_reset();
    check(32'(write_adr), 32'h0, "write pointer after second power-up");
    set_ang(15'h0ABC);
    rd(ADR_ANGLE15, 16'h0ABC);
    give_verdict();
  end
endmodule : testbench
